//--- inc/sppwb_pkg.sv
// Constants for the servo parameter write-protect bank.
// Assumes a 16-bit parameter word and a word-indexed register port.
package sppwb_pkg;

  // ------------------------------------------------------------------
  // Port geometry
  // ------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int GRP_MSB = 7;
  localparam int GRP_LSB = 6;
  localparam int IDX_W = 6;

  // ------------------------------------------------------------------
  // Parameter groups
  // ------------------------------------------------------------------
  localparam logic [1:0] GRP_BASIC = 2'h0;
  localparam logic [1:0] GRP_GAIN = 2'h1;
  localparam logic [1:0] GRP_EXT = 2'h2;
  localparam logic [1:0] GRP_IO = 2'h3;

  // ------------------------------------------------------------------
  // Basic group indices
  // ------------------------------------------------------------------
  localparam logic [5:0] IDX_CMD_SYS = 6'h01;
  localparam logic [5:0] IDX_REGEN = 6'h02;
  localparam logic [5:0] IDX_POS_SYS = 6'h03;
  localparam logic [5:0] IDX_GEAR_NUM = 6'h06;
  localparam logic [5:0] IDX_GEAR_DEN = 6'h07;
  localparam logic [5:0] IDX_INHIBIT = 6'h13;
  localparam logic [5:0] IDX_STATUS = 6'h30;
  localparam logic [5:0] IDX_MASK = 6'h31;
  localparam logic [5:0] IDX_FLAGS = 6'h32;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] RST_INHIBIT = 16'h000c;
  localparam logic [15:0] RST_CMD_SYS = 16'h0000;
  localparam logic [15:0] RST_REGEN = 16'h0000;
  localparam logic [15:0] RST_POS_SYS = 16'h0000;
  localparam logic [15:0] RST_GEAR = 16'h0001;

  // ------------------------------------------------------------------
  // Write-inhibit codes
  // ------------------------------------------------------------------
  localparam logic [15:0] INH_BASIC = 16'h0000;
  localparam logic [15:0] INH_THREE_WR = 16'h000b;
  localparam logic [15:0] INH_ALL = 16'h000c;
  localparam logic [15:0] INH_THREE_RD = 16'h000d;
  localparam logic [15:0] INH_RO_BASIC = 16'h100b;
  localparam logic [15:0] INH_RO_ALL = 16'h100c;

  // ------------------------------------------------------------------
  // Field layout
  // ------------------------------------------------------------------
  localparam int DIGIT_W = 4;
  localparam logic [3:0] DIGIT_ONE = 4'h1;
  localparam int REGEN_W = 4;

  // ------------------------------------------------------------------
  // Gear limits
  // ------------------------------------------------------------------
  localparam logic [15:0] GEAR_MIN = 16'h0001;
  localparam logic [15:0] GEAR_MAX = 16'h4000;
  localparam logic [31:0] RATIO_LIMIT = 32'h0000270f;
  localparam logic [31:0] DEN_STN_LIMIT = 32'h00007fff;
  localparam logic [31:0] PRODUCT_LIMIT = 32'h000186a0;
  localparam int STN_W = 8;

  // ------------------------------------------------------------------
  // Status, mask and flag bits
  // ------------------------------------------------------------------
  localparam int EVT_W = 3;
  localparam int EVT_REF_DENIED = 0;
  localparam int EVT_WR_DENIED = 1;
  localparam int EVT_PARAM_ERR = 2;
  localparam int FLAG_PARAM_ERR = 0;
  localparam int FLAG_PENDING = 1;

endpackage

//--- design/sppwb_access_check.sv
// Grant decode of the write-inhibit word for one access.
// Assumes the active inhibit word, already latched at power-up.
`timescale 1ns/1ps
module sppwb_access_check (
  // Active inhibit word
  input wire logic [15:0] inhibit_i,
  // Access under test
  input wire logic [1:0] group_i,
  input wire logic is_inhibit_reg_i,
  // Grants
  output logic ref_ok_o,
  output logic wr_ok_o
);

  // ------------------------------------------------------------------
  // Grant function
  // ------------------------------------------------------------------
  function automatic logic grant(input logic [15:0] inh, input logic [1:0] grp,
                                 input logic is_inh, input logic want_wr);
    logic ok;
    ok = 1'b0;
    if (inh == sppwb_pkg::INH_BASIC) begin
      ok = (grp == sppwb_pkg::GRP_BASIC);
    end else if (inh == sppwb_pkg::INH_THREE_WR || inh == sppwb_pkg::INH_THREE_RD) begin
      ok = (grp != sppwb_pkg::GRP_IO);
    end else if (inh == sppwb_pkg::INH_ALL) begin
      ok = 1'b1;
    end else if (inh == sppwb_pkg::INH_RO_BASIC) begin
      ok = want_wr ? is_inh : (grp == sppwb_pkg::GRP_BASIC);
    end else if (inh == sppwb_pkg::INH_RO_ALL) begin
      ok = want_wr ? is_inh : 1'b1;
    end else begin
      ok = want_wr & is_inh;
    end
    return ok;
  endfunction

  assign ref_ok_o = grant(inhibit_i, group_i, is_inhibit_reg_i, 1'b0);
  assign wr_ok_o = grant(inhibit_i, group_i, is_inhibit_reg_i, 1'b1);

endmodule

//--- design/sppwb_gear_check.sv
// Electronic gear consistency check.
// Assumes both gear counts already lie in their accepted range.
`timescale 1ns/1ps
module sppwb_gear_check (
  // Gear counts
  input wire logic [15:0] num_i,
  input wire logic [15:0] den_i,
  input wire logic [7:0] stn_i,
  // Result
  output logic gear_err_o
);

  logic [31:0] num_w;
  logic [31:0] den_w;
  logic [31:0] stn_w;
  logic ratio_low;
  logic ratio_high;
  logic stn_over;
  logic prod_over;

  assign num_w = {16'h0000, num_i};
  assign den_w = {16'h0000, den_i};
  assign stn_w = {24'h000000, stn_i};

  // ------------------------------------------------------------------
  // Ratio, station and product limits
  // ------------------------------------------------------------------
  // ratio, station and product limits
  assign ratio_low = (num_w * sppwb_pkg::RATIO_LIMIT) < den_w;
  assign ratio_high = num_w > (den_w * sppwb_pkg::RATIO_LIMIT);
  assign stn_over = (den_w * stn_w) > sppwb_pkg::DEN_STN_LIMIT;
  assign prod_over = (num_w * den_w) > sppwb_pkg::PRODUCT_LIMIT;
  assign gear_err_o = ratio_low | ratio_high | stn_over | prod_over;

endmodule

//--- design/sppwb_bank.sv
// Servo basic-parameter bank with write-inhibit gating of four groups.
// Assumes one clock, synchronous reset, and a power-up load pulse that
// stands for the completion of a power cycle.
`timescale 1ns/1ps
module sppwb_bank #(
  parameter int GRP_WORDS = 16,
  parameter logic [15:0] REGEN_USABLE = 16'h0001
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Power cycle completed
  input wire logic power_on_load_i,
  // Register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rd_data_o,
  // System inputs
  input wire logic [7:0] station_count_i,
  // Active settings
  output logic control_kind_o,
  output logic absolute_detect_o,
  output logic [3:0] regen_code_o,
  output logic [15:0] machine_gear_count_o,
  output logic [15:0] motor_gear_count_o,
  output logic [15:0] write_lock_o,
  // Status
  output logic parameter_error_o,
  output logic irq_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] inhibit;
    logic [15:0] cmd_sys;
    logic [15:0] regen;
    logic [15:0] pos_sys;
    logic [15:0] gear_num;
    logic [15:0] gear_den;
  } sppwb_params_s;

  typedef struct packed {
    sppwb_params_s pend;
    sppwb_params_s act;
    logic [2:0][GRP_WORDS-1:0][15:0] ext;
    logic [2:0] status;
    logic [2:0] mask;
    logic err;
    logic [15:0] rdata;
  } sppwb_state_s;

  sppwb_state_s st_q;
  sppwb_state_s st_d;

  localparam sppwb_params_s PARAMS_RST = '{
    inhibit: sppwb_pkg::RST_INHIBIT,
    cmd_sys: sppwb_pkg::RST_CMD_SYS,
    regen: sppwb_pkg::RST_REGEN,
    pos_sys: sppwb_pkg::RST_POS_SYS,
    gear_num: sppwb_pkg::RST_GEAR,
    gear_den: sppwb_pkg::RST_GEAR
  };

  // ------------------------------------------------------------------
  // Address split
  // ------------------------------------------------------------------
  logic [1:0] grp;
  logic [5:0] idx;
  logic is_inh;
  logic is_ctrl;
  logic ext_hit;
  logic [1:0] ext_sel;

  assign grp = addr_i[sppwb_pkg::GRP_MSB:sppwb_pkg::GRP_LSB];
  assign idx = addr_i[sppwb_pkg::IDX_W-1:0];
  assign is_inh = (grp == sppwb_pkg::GRP_BASIC) && (idx == sppwb_pkg::IDX_INHIBIT);
  assign is_ctrl = (grp == sppwb_pkg::GRP_BASIC) &&
                   (idx == sppwb_pkg::IDX_STATUS || idx == sppwb_pkg::IDX_MASK ||
                    idx == sppwb_pkg::IDX_FLAGS);
  assign ext_hit = (grp != sppwb_pkg::GRP_BASIC) && (int'(idx) < GRP_WORDS);
  assign ext_sel = 2'(grp - 2'h1);

  // ------------------------------------------------------------------
  // Grant decode and gear check
  // ------------------------------------------------------------------
  logic ref_ok;
  logic wr_ok;
  logic gear_err;
  logic regen_bad;
  logic err_now;

  sppwb_access_check u_access (
    .inhibit_i(st_q.act.inhibit),
    .group_i(grp),
    .is_inhibit_reg_i(is_inh),
    .ref_ok_o(ref_ok),
    .wr_ok_o(wr_ok)
  );

  sppwb_gear_check u_gear (
    .num_i(st_q.act.gear_num),
    .den_i(st_q.act.gear_den),
    .stn_i(station_count_i),
    .gear_err_o(gear_err)
  );

  assign regen_bad = ~REGEN_USABLE[st_q.act.regen[sppwb_pkg::REGEN_W-1:0]];
  assign err_now = regen_bad | gear_err;

  // ------------------------------------------------------------------
  // Gear range test
  // ------------------------------------------------------------------
  function automatic logic gear_in_range(input logic [15:0] v);
    return (v >= sppwb_pkg::GEAR_MIN) && (v <= sppwb_pkg::GEAR_MAX);
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  logic [2:0] evt;
  logic [2:0] clr;
  logic [15:0] flags;

  always_comb begin
    st_d = st_q;
    st_d.rdata = 16'h0000;
    evt = 3'h0;
    clr = 3'h0;
    flags = 16'h0000;
    flags[sppwb_pkg::FLAG_PARAM_ERR] = st_q.err;
    flags[sppwb_pkg::FLAG_PENDING] = (st_q.pend != st_q.act);

    // Writes
    if (wr_i) begin
      if (grp == sppwb_pkg::GRP_BASIC && idx == sppwb_pkg::IDX_STATUS) begin
        clr = wr_data_i[sppwb_pkg::EVT_W-1:0];
      end else if (grp == sppwb_pkg::GRP_BASIC && idx == sppwb_pkg::IDX_MASK) begin
        st_d.mask = wr_data_i[sppwb_pkg::EVT_W-1:0];
      end else if (is_ctrl) begin
        st_d.mask = st_q.mask;
      end else if (!wr_ok) begin
        evt[sppwb_pkg::EVT_WR_DENIED] = 1'b1;
      end else if (grp == sppwb_pkg::GRP_BASIC) begin
        if (idx == sppwb_pkg::IDX_INHIBIT) begin
          st_d.pend.inhibit = wr_data_i;
        end else if (idx == sppwb_pkg::IDX_CMD_SYS) begin
          st_d.pend.cmd_sys = wr_data_i;
        end else if (idx == sppwb_pkg::IDX_REGEN) begin
          st_d.pend.regen = wr_data_i;
        end else if (idx == sppwb_pkg::IDX_POS_SYS) begin
          st_d.pend.pos_sys = wr_data_i;
        end else if (idx == sppwb_pkg::IDX_GEAR_NUM) begin
          if (gear_in_range(wr_data_i)) begin
            st_d.pend.gear_num = wr_data_i;
          end else begin
            evt[sppwb_pkg::EVT_WR_DENIED] = 1'b1;
          end
        end else if (idx == sppwb_pkg::IDX_GEAR_DEN) begin
          if (gear_in_range(wr_data_i)) begin
            st_d.pend.gear_den = wr_data_i;
          end else begin
            evt[sppwb_pkg::EVT_WR_DENIED] = 1'b1;
          end
        end
      end else if (ext_hit) begin
        st_d.ext[ext_sel][idx[$clog2(GRP_WORDS)-1:0]] = wr_data_i;
      end
    end

    // Reads, data one cycle later
    if (rd_i) begin
      if (grp == sppwb_pkg::GRP_BASIC && idx == sppwb_pkg::IDX_STATUS) begin
        st_d.rdata = {13'h0000, st_q.status};
      end else if (grp == sppwb_pkg::GRP_BASIC && idx == sppwb_pkg::IDX_MASK) begin
        st_d.rdata = {13'h0000, st_q.mask};
      end else if (grp == sppwb_pkg::GRP_BASIC && idx == sppwb_pkg::IDX_FLAGS) begin
        st_d.rdata = flags;
      end else if (!ref_ok) begin
        evt[sppwb_pkg::EVT_REF_DENIED] = 1'b1;
      end else if (grp == sppwb_pkg::GRP_BASIC) begin
        if (idx == sppwb_pkg::IDX_INHIBIT) begin
          st_d.rdata = st_q.pend.inhibit;
        end else if (idx == sppwb_pkg::IDX_CMD_SYS) begin
          st_d.rdata = st_q.pend.cmd_sys;
        end else if (idx == sppwb_pkg::IDX_REGEN) begin
          st_d.rdata = st_q.pend.regen;
        end else if (idx == sppwb_pkg::IDX_POS_SYS) begin
          st_d.rdata = st_q.pend.pos_sys;
        end else if (idx == sppwb_pkg::IDX_GEAR_NUM) begin
          st_d.rdata = st_q.pend.gear_num;
        end else if (idx == sppwb_pkg::IDX_GEAR_DEN) begin
          st_d.rdata = st_q.pend.gear_den;
        end
      end else if (ext_hit) begin
        st_d.rdata = st_q.ext[ext_sel][idx[$clog2(GRP_WORDS)-1:0]];
      end
    end

    // pending copy takes effect at power-up
    if (power_on_load_i) begin
      st_d.act = st_d.pend;
    end

    // Error edge and sticky status, set wins
    st_d.err = err_now;
    evt[sppwb_pkg::EVT_PARAM_ERR] = err_now & ~st_q.err;
    st_d.status = (st_q.status & ~clr) | evt;
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      st_q.pend <= PARAMS_RST;
      st_q.act <= PARAMS_RST;
      st_q.ext <= '0;
      st_q.status <= 3'h0;
      st_q.mask <= 3'h0;
      st_q.err <= 1'b0;
      st_q.rdata <= 16'h0000;
    end else begin
      st_q <= st_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign rd_data_o = st_q.rdata;
  assign control_kind_o = (st_q.act.cmd_sys[sppwb_pkg::DIGIT_W-1:0] == sppwb_pkg::DIGIT_ONE);
  assign absolute_detect_o =
    (st_q.act.pos_sys[sppwb_pkg::DIGIT_W-1:0] == sppwb_pkg::DIGIT_ONE);
  assign regen_code_o = st_q.act.regen[sppwb_pkg::REGEN_W-1:0];
  assign machine_gear_count_o = st_q.act.gear_num;
  assign motor_gear_count_o = st_q.act.gear_den;
  assign write_lock_o = st_q.act.inhibit;
  assign parameter_error_o = st_q.err;
  assign irq_o = |(st_q.status & st_q.mask);

endmodule

//--- test/sppwb_host_model.sv
// Host model: setup software on the bank's register port.
// Assumes reads answer in the cycle after the strobe.
`timescale 1ns/1ps
module sppwb_host_model (
  // Clock
  input wire logic mclk_i,
  // Register port
  output logic [7:0] addr_o,
  output logic [15:0] wr_data_o,
  output logic wr_o,
  output logic rd_o,
  input wire logic [15:0] rd_data_i
);
  initial begin
    addr_o = 8'h00;
    wr_data_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Idle bus shows inverted stale values
  task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    wr_data_o <= d;
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wr_data_o <= ~d;
  endtask
  task automatic bus_read(input logic [7:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    @(posedge mclk_i);
    d = rd_data_i;
  endtask
endmodule

//--- test/sppwb_bank_properties.sv
// Port checker for the parameter bank.
// Assumes it is bound to every bank instance.
`timescale 1ns/1ps
module sppwb_bank_properties #(
  parameter logic [15:0] REGEN_USABLE = 16'h0001
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Watched ports
  input wire logic power_on_load_i,
  input wire logic rd_i,
  input wire logic [15:0] rd_data_o,
  input wire logic [7:0] station_count_i,
  input wire logic control_kind_o,
  input wire logic absolute_detect_o,
  input wire logic [3:0] regen_code_o,
  input wire logic [15:0] machine_gear_count_o,
  input wire logic [15:0] motor_gear_count_o,
  input wire logic [15:0] write_lock_o,
  input wire logic parameter_error_o
);
  logic [31:0] n_w;
  logic [31:0] d_w;
  logic gear_bad;
  logic regen_bad;
  assign n_w = {16'h0000, machine_gear_count_o};
  assign d_w = {16'h0000, motor_gear_count_o};
  assign gear_bad = (n_w * sppwb_pkg::RATIO_LIMIT < d_w) ||
    (n_w > d_w * sppwb_pkg::RATIO_LIMIT) ||
    (d_w * {24'h000000, station_count_i} > sppwb_pkg::DEN_STN_LIMIT) ||
    (n_w * d_w > sppwb_pkg::PRODUCT_LIMIT);
  assign regen_bad = !REGEN_USABLE[regen_code_o];
  default clocking dcb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  property p_rd_idle;
    !rd_i |=> rd_data_o == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_lock_hold;
    !power_on_load_i |=> $stable(write_lock_o);
  endproperty
  a_lock_hold: assert property (p_lock_hold) else $error("lock moved without load");
  property p_set_hold;
    !power_on_load_i |=> $stable({control_kind_o, absolute_detect_o, regen_code_o,
      machine_gear_count_o, motor_gear_count_o});
  endproperty
  a_set_hold: assert property (p_set_hold) else $error("setting moved without load");
  property p_num_range;
    machine_gear_count_o >= 16'h0001 && machine_gear_count_o <= 16'h4000;
  endproperty
  a_num_range: assert property (p_num_range) else $error("numerator out of range");
  property p_den_range;
    motor_gear_count_o >= 16'h0001 && motor_gear_count_o <= 16'h4000;
  endproperty
  a_den_range: assert property (p_den_range) else $error("denominator out of range");
  property p_regen_err;
    regen_bad |=> parameter_error_o;
  endproperty
  a_regen_err: assert property (p_regen_err) else $error("regen error missing");
  property p_gear_err;
    gear_bad |=> parameter_error_o;
  endproperty
  a_gear_err: assert property (p_gear_err) else $error("gear error missing");
  property p_no_err;
    !gear_bad && !regen_bad |=> !parameter_error_o;
  endproperty
  a_no_err: assert property (p_no_err) else $error("spurious parameter error");
endmodule
bind sppwb_bank sppwb_bank_properties #(.REGEN_USABLE(REGEN_USABLE)) sppwb_bank_properties_inst (
  .mclk_i, .rst_n_i, .power_on_load_i, .rd_i, .rd_data_o, .station_count_i,
  .control_kind_o, .absolute_detect_o, .regen_code_o, .machine_gear_count_o,
  .motor_gear_count_o, .write_lock_o, .parameter_error_o
);

//--- test/test_sppwb_bank.sv
// Self-checking bench for the parameter bank.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module test_sppwb_bank;
  localparam logic [7:0] A_INH = {2'h0, sppwb_pkg::IDX_INHIBIT};
  localparam logic [7:0] A_CMD = {2'h0, sppwb_pkg::IDX_CMD_SYS};
  localparam logic [7:0] A_REG = {2'h0, sppwb_pkg::IDX_REGEN};
  localparam logic [7:0] A_POS = {2'h0, sppwb_pkg::IDX_POS_SYS};
  localparam logic [7:0] A_NUM = {2'h0, sppwb_pkg::IDX_GEAR_NUM};
  localparam logic [7:0] A_DEN = {2'h0, sppwb_pkg::IDX_GEAR_DEN};
  localparam logic [7:0] A_STA = {2'h0, sppwb_pkg::IDX_STATUS};
  localparam logic [7:0] A_MSK = {2'h0, sppwb_pkg::IDX_MASK};
  localparam logic [7:0] A_FLG = {2'h0, sppwb_pkg::IDX_FLAGS};
  logic mclk_i;
  logic rst_n_i;
  logic power_on_load_i;
  logic [7:0] addr_i;
  logic [15:0] wr_data_i;
  logic wr_i;
  logic rd_i;
  logic [15:0] rd_data_o;
  logic [7:0] station_count_i;
  logic control_kind_o;
  logic absolute_detect_o;
  logic [3:0] regen_code_o;
  logic [15:0] machine_gear_count_o;
  logic [15:0] motor_gear_count_o;
  logic [15:0] write_lock_o;
  logic parameter_error_o;
  logic irq_o;
  int errors;
  int samples_checked;
  logic [15:0] rdv;
  sppwb_bank sppwb_bank_inst (
    .mclk_i, .rst_n_i, .power_on_load_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
    .station_count_i, .control_kind_o, .absolute_detect_o, .regen_code_o,
    .machine_gear_count_o, .motor_gear_count_o, .write_lock_o, .parameter_error_o, .irq_o
  );
  sppwb_host_model sppwb_host_model_inst (
    .mclk_i, .addr_o(addr_i), .wr_data_o(wr_data_i), .wr_o(wr_i), .rd_o(rd_i),
    .rd_data_i(rd_data_o)
  );
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  // --------
  // Helpers
  // --------
  task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    sppwb_host_model_inst.bus_write(a, d);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [15:0] e);
    sppwb_host_model_inst.bus_read(a, rdv);
    check(n, rdv, e);
  endtask
  task automatic power_cycle();
    @(posedge mclk_i);
    power_on_load_i <= 1'b1;
    @(posedge mclk_i);
    power_on_load_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  task automatic results();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reset();
    rdc("inhibit", A_INH, 16'h000c);
    rdc("cmd", A_CMD, 16'h0000);
    rdc("regen", A_REG, 16'h0000);
    rdc("pos", A_POS, 16'h0000);
    rdc("num", A_NUM, 16'h0001);
    rdc("den", A_DEN, 16'h0001);
    check("lock", write_lock_o, 16'h000c);
  endtask
  task automatic t_grants();
    logic [15:0] codes [7] = '{16'h0000, 16'h000b, 16'h000d, 16'h100b, 16'h100c, 16'h0001,
      16'h000c};
    logic [3:0] refm [7] = '{4'h1, 4'h7, 4'h7, 4'h1, 4'hf, 4'h0, 4'hf};
    logic [3:0] wrm [7] = '{4'h1, 4'h7, 4'h7, 4'h0, 4'h0, 4'h0, 4'hf};
    logic [15:0] mem [4] = '{16'h0001, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] prev = 16'h000c;
    logic [15:0] v;
    logic [7:0] a;
    for (int k = 0; k < 7; k++) begin
      wr(A_INH, codes[k]);
      check("lock before load", write_lock_o, prev);
      power_cycle();
      check("lock", write_lock_o, codes[k]);
      prev = codes[k];
      wr(A_STA, 16'h0007);
      for (int g = 0; g < 4; g++) begin
        v = 16'h0011 + 16'(k * 16 + g);
        a = (g == 0) ? A_NUM : {g[1:0], 6'h05};
        wr(a, v);
        if (wrm[k][g]) mem[g] = v;
        rdc("group word", a, refm[k][g] ? mem[g] : 16'h0000);
      end
      rdc("status", A_STA, {14'h0000, wrm[k] != 4'hf, refm[k] != 4'hf});
    end
  endtask
  task automatic t_modes();
    for (int v = 1; v >= 0; v--) begin
      wr(A_CMD, 16'(v));
      wr(A_POS, 16'(v));
      wr(A_REG, 16'(v));
      check("kind before load", {15'h0000, control_kind_o}, 16'(1 - v));
      power_cycle();
      check("kind", {15'h0000, control_kind_o}, 16'(v));
      check("absolute", {15'h0000, absolute_detect_o}, 16'(v));
      check("regen err", {15'h0000, parameter_error_o}, 16'(v));
      check("regen code", {12'h000, regen_code_o}, 16'(v));
      rdc("flags", A_FLG, 16'(v));
      rdc("err event", A_STA, 16'(4 * v));
      wr(A_STA, 16'h0004);
    end
  endtask
  task automatic t_gear();
    logic [15:0] gn [6] = '{16'h4000, 16'h4000, 16'h0001, 16'h0190, 16'h0001, 16'h0001};
    logic [15:0] gd [6] = '{16'h0001, 16'h0002, 16'h00c8, 16'h012c, 16'h4000, 16'h0001};
    logic [7:0] gs [6] = '{8'h08, 8'h08, 8'hc8, 8'h08, 8'h01, 8'h08};
    logic eb [6] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    wr(A_NUM, 16'h4001);
    wr(A_DEN, 16'h0000);
    rdc("num kept", A_NUM, 16'h0071);
    rdc("den kept", A_DEN, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      wr(A_NUM, gn[i]);
      wr(A_DEN, gd[i]);
      station_count_i <= gs[i];
      power_cycle();
      check("gear err", {15'h0000, parameter_error_o}, {15'h0000, eb[i]});
      check("num", machine_gear_count_o, gn[i]);
      check("den", motor_gear_count_o, gd[i]);
    end
  endtask
  task automatic t_irq();
    wr(A_STA, 16'h0007);
    wr(A_MSK, 16'h0000);
    wr(A_NUM, 16'h0000);
    wr({2'h0, 6'h20}, 16'h1234);
    rdc("unmapped", {2'h0, 6'h20}, 16'h0000);
    rdc("status", A_STA, 16'h0002);
    check("irq masked", {15'h0000, irq_o}, 16'h0000);
    wr(A_MSK, 16'h0002);
    rdc("mask", A_MSK, 16'h0002);
    check("irq", {15'h0000, irq_o}, 16'h0001);
    wr(A_STA, 16'h0002);
    repeat (2) @(posedge mclk_i);
    check("irq cleared", {15'h0000, irq_o}, 16'h0000);
  endtask
  initial begin
    errors = 0;
    samples_checked = 0;
    rst_n_i = 1'b0;
    power_on_load_i = 1'b0;
    station_count_i = 8'h08;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_grants();
    t_modes();
    t_gear();
    t_irq();
    results();
  end
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    results();
  end
endmodule
